/* File: core/pcmpm_pkg.sv */
`default_nettype none

package pcmpm_pkg;

  // ----------------------------------------
  // Strap codes and link framing
  // ----------------------------------------
  localparam logic [1:0] TERN_N = 2'h0;
  localparam logic [1:0] TERN_O = 2'h1;
  localparam logic [1:0] TERN_P = 2'h2;
  localparam int WORD_BITS = 16;
  localparam int SLOT_BITS = 32;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CNT_MAX = 9'h1FF;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LATCH = 8'h08;
  localparam int CTRL_W = 7;
  localparam int CTRL_PWRDN_BIT = 0;
  localparam int CTRL_SBDIR_LSB = 1;
  localparam int CTRL_CIDIR_LSB = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h01;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic bus_mode;
    logic fast;
    logic [2:0] slot;
  } pcmpm_cfg_t;

  typedef struct packed {
    logic mode;
    logic [1:0] ts1;
    logic [1:0] ts2;
    logic sclk;
    logic dir;
    logic sdat;
    logic [5:0] sig_in;
    logic [1:0] sb;
    logic bus_data_clock;
    logic bus_frame_strobe;
    logic dd;
    logic [1:0] ind;
    logic [3:0] ci;
  } pcmpm_pins_t;

  function automatic pcmpm_cfg_t pcmpm_decode(input logic mode, input logic [1:0] ts1, input logic [1:0] ts2);
    pcmpm_cfg_t c;
    c = '{valid: 1'b1, bus_mode: mode, fast: 1'b1, slot: 3'h0};
    case ({ts1, ts2})
      {TERN_O, TERN_O}: c.slot = 3'h0;
      {TERN_O, TERN_N}: c.slot = 3'h1;
      {TERN_P, TERN_O}: c.slot = 3'h2;
      {TERN_P, TERN_N}: c.slot = 3'h3;
      {TERN_O, TERN_P}: c.slot = 3'h4;
      {TERN_N, TERN_O}: c.slot = 3'h5;
      {TERN_P, TERN_P}: c.slot = 3'h6;
      {TERN_N, TERN_P}: c.slot = 3'h7;
      default: c.fast = 1'b0;
    endcase
    return c;
  endfunction

endpackage : pcmpm_pkg

`default_nettype wire

/* File: core/pcmpm_top.sv */
`default_nettype none

module pcmpm_top import pcmpm_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Straps
  input wire logic mode_select_i,
  input wire logic [1:0] slot_strap_first_i,
  input wire logic [1:0] slot_strap_second_i,
  // Slot-link port
  input wire logic slave_clock_i,
  input wire logic dir_strobe_i,
  input wire logic shared_serial_data_pin_i,
  output logic shared_serial_data_pin_o,
  output logic shared_serial_data_pin_oe_o,
  input wire logic [5:0] sig_in_i,
  output logic [5:0] sig_out_o,
  input wire logic [1:0] sig_bidir_i,
  output logic [1:0] sig_bidir_o,
  output logic [1:0] sig_bidir_oe_o,
  // Multiplexed-bus port
  input wire logic bus_data_clock_i,
  input wire logic bus_frame_strobe_i,
  input wire logic downstream_data_in_i,
  output logic upstream_data_out_o,
  input wire logic [1:0] indication_in_i,
  output logic [4:0] command_out_o,
  input wire logic [3:0] cmd_ind_bidir_i,
  output logic [3:0] cmd_ind_bidir_o,
  output logic [3:0] cmd_ind_bidir_oe_o,
  output logic power_down_o
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  pcmpm_pins_t pins_raw, sync1_q, sync2_q;
  assign pins_raw = {mode_select_i, slot_strap_first_i, slot_strap_second_i, slave_clock_i, dir_strobe_i,
                     shared_serial_data_pin_i, sig_in_i, sig_bidir_i, bus_data_clock_i, bus_frame_strobe_i,
                     downstream_data_in_i, indication_in_i, cmd_ind_bidir_i};

  always_ff @(posedge clk_i) begin
    sync1_q <= pins_raw;
    sync2_q <= sync1_q;
  end

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // Straps are static, so one capture after reset release avoids mid-frame slot jumps
  pcmpm_cfg_t cfg_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_q <= '0;
    end else if (!cfg_q.valid) begin
      cfg_q <= pcmpm_decode(sync2_q.mode, sync2_q.ts1, sync2_q.ts2);
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic pwrdn;
  logic [1:0] sb_dir;
  logic [3:0] ci_dir;
  assign pwrdn = ctrl_q[CTRL_PWRDN_BIT];
  assign sb_dir = ctrl_q[CTRL_SBDIR_LSB +: 2];
  assign ci_dir = ctrl_q[CTRL_CIDIR_LSB +: 4];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_pend_q && addr_q == REG_CTRL) begin
      ctrl_q <= hwdata_i[CTRL_W-1:0];
    end
  end

  // ----------------------------------------
  // Link edge detection
  // ----------------------------------------
  logic lclk, strb, rxd, lclk_prev_q, strb_q, rise, fall, run, frame_edge;
  assign lclk = cfg_q.bus_mode ? sync2_q.bus_data_clock : sync2_q.sclk;
  assign strb = cfg_q.bus_mode ? sync2_q.bus_frame_strobe : sync2_q.dir;
  assign rxd = cfg_q.bus_mode ? sync2_q.dd : sync2_q.sdat;
  assign rise = lclk && !lclk_prev_q;
  assign fall = !lclk && lclk_prev_q;
  assign run = cfg_q.valid && !(cfg_q.bus_mode && pwrdn);
  // Slot-link restarts the count on both strobe edges, bus mode on the rising one only
  assign frame_edge = rise && (strb != strb_q) && (cfg_q.bus_mode ? strb : 1'b1);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lclk_prev_q <= 1'b0;
      strb_q <= 1'b0;
    end else begin
      lclk_prev_q <= lclk;
      if (rise) begin
        strb_q <= strb;
      end
    end
  end

  // ----------------------------------------
  // Bit counter and slot window
  // ----------------------------------------
  logic [CNT_W-1:0] cnt_q, cnt_n, win_start;
  logic tx_win_n, rx_win;
  assign cnt_n = frame_edge ? '0 : ((cnt_q == CNT_MAX) ? cnt_q : cnt_q + 1'b1);
  assign win_start = (cfg_q.bus_mode && cfg_q.fast) ? CNT_W'(cfg_q.slot * SLOT_BITS) : '0;
  assign tx_win_n = (cnt_n >= win_start) && (cnt_n < win_start + CNT_W'(WORD_BITS)) && (cfg_q.bus_mode || !strb);
  assign rx_win = (cnt_q >= win_start) && (cnt_q < win_start + CNT_W'(WORD_BITS)) && (cfg_q.bus_mode || strb_q);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= CNT_MAX;
    end else if (rise) begin
      cnt_q <= cnt_n;
    end
  end

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  logic [WORD_BITS-1:0] tx_word, tx_sh_q;
  logic txd_q, sdat_oe_q;
  assign tx_word = cfg_q.bus_mode ? {sync2_q.ind, sync2_q.ci, 10'h000}
                                  : {sync2_q.sig_in, sync2_q.sb, 8'h00};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_sh_q <= '0;
      txd_q <= 1'b1;
      sdat_oe_q <= 1'b0;
    end else if (!run) begin
      txd_q <= 1'b1;
      sdat_oe_q <= 1'b0;
    end else if (rise) begin
      sdat_oe_q <= !cfg_q.bus_mode && tx_win_n;
      if (tx_win_n && cnt_n == win_start) begin
        txd_q <= tx_word[WORD_BITS-1];
        tx_sh_q <= {tx_word[WORD_BITS-2:0], 1'b0};
      end else if (tx_win_n) begin
        txd_q <= tx_sh_q[WORD_BITS-1];
        tx_sh_q <= {tx_sh_q[WORD_BITS-2:0], 1'b0};
      end else begin
        txd_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Receive path and output latches
  // ----------------------------------------
  // Outputs only move once a whole word is in, so a torn frame never reaches the pins
  logic [WORD_BITS-1:0] rx_sh_q, rx_full;
  logic [4:0] rx_cnt_q;
  logic [5:0] sig_out_q;
  logic [1:0] sb_out_q;
  logic [4:0] cmd_out_q;
  logic [3:0] ci_out_q;
  assign rx_full = {rx_sh_q[WORD_BITS-2:0], rxd};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_sh_q <= '0;
      rx_cnt_q <= '0;
      sig_out_q <= '0;
      sb_out_q <= '0;
      cmd_out_q <= '0;
      ci_out_q <= '0;
    end else if (frame_edge) begin
      rx_cnt_q <= '0;
    end else if (run && fall && rx_win && rx_cnt_q < 5'(WORD_BITS)) begin
      rx_sh_q <= rx_full;
      rx_cnt_q <= rx_cnt_q + 5'h01;
      if (rx_cnt_q == 5'(WORD_BITS - 1)) begin
        if (cfg_q.bus_mode) begin
          cmd_out_q <= rx_full[15:11];
          ci_out_q <= rx_full[10:7];
        end else begin
          sig_out_q <= rx_full[15:10];
          sb_out_q <= rx_full[9:8];
        end
      end
    end
  end

  // ----------------------------------------
  // Pin direction
  // ----------------------------------------
  logic [1:0] sb_oe_q;
  logic [3:0] ci_oe_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sb_oe_q <= '0;
      ci_oe_q <= '0;
    end else begin
      sb_oe_q <= (cfg_q.valid && !cfg_q.bus_mode) ? sb_dir : 2'h0;
      ci_oe_q <= (cfg_q.valid && cfg_q.bus_mode) ? ci_dir : 4'h0;
    end
  end

  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  logic [31:0] hrdata_q, rd_mux;
  logic [CTRL_W-1:0] ctrl_view;
  logic accept;
  assign accept = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
  // Bypass so a read right after a write to the same register sees the new value
  assign ctrl_view = (wr_pend_q && addr_q == REG_CTRL) ? hwdata_i[CTRL_W-1:0] : ctrl_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr_i[7:0] == REG_CTRL) begin
      rd_mux = {25'h0, ctrl_view};
    end else if (haddr_i[7:0] == REG_STATUS) begin
      rd_mux = {12'h000, sync2_q.ci, sync2_q.ind, sync2_q.sb, sync2_q.sig_in, cfg_q.slot, cfg_q.fast,
                cfg_q.bus_mode, cfg_q.valid};
    end else if (haddr_i[7:0] == REG_LATCH) begin
      rd_mux = {15'h0, ci_out_q, cmd_out_q, sb_out_q, sig_out_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= accept && hwrite_i;
      if (accept) begin
        addr_q <= haddr_i[7:0];
        hrdata_q <= hwrite_i ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hrdata_o = hrdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign shared_serial_data_pin_o = txd_q;
  assign shared_serial_data_pin_oe_o = sdat_oe_q;
  assign upstream_data_out_o = txd_q;
  assign sig_out_o = sig_out_q;
  assign sig_bidir_o = sb_out_q;
  assign sig_bidir_oe_o = sb_oe_q;
  assign command_out_o = cmd_out_q;
  assign cmd_ind_bidir_o = ci_out_q;
  assign cmd_ind_bidir_oe_o = ci_oe_q;
  assign power_down_o = ctrl_q[CTRL_PWRDN_BIT];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_cfg_frozen: assert property (cfg_q.valid |=> $stable(cfg_q))
    else $error("strap decode changed after capture");
  a_mode_strap: assert property ($rose(cfg_q.valid) |-> cfg_q.bus_mode == $past(sync2_q.mode))
    else $error("mode does not follow strap");
  a_slow_strap: assert property ($rose(cfg_q.valid) && $past(sync2_q.ts1) == TERN_N
      && $past(sync2_q.ts2) == TERN_N |-> !cfg_q.fast)
    else $error("N,N did not give slow mode");
  a_slot_seven: assert property ($rose(cfg_q.valid) && $past(sync2_q.ts1) == TERN_N
      && $past(sync2_q.ts2) == TERN_P |-> cfg_q.fast && cfg_q.slot == 3'h7)
    else $error("N,P did not give slot 7");
  a_slot_three: assert property ($rose(cfg_q.valid) && $past(sync2_q.ts1) == TERN_P
      && $past(sync2_q.ts2) == TERN_N |-> cfg_q.fast && cfg_q.slot == 3'h3)
    else $error("P,N did not give slot 3");
  a_sip_turn: assert property (sdat_oe_q |-> !cfg_q.bus_mode && !strb_q)
    else $error("shared pin driven in controller phase");
  a_latch_hold: assert property (!fall |=> $stable(sig_out_q) && $stable(cmd_out_q))
    else $error("latched outputs moved without a link edge");
  a_sb_dir: assert property (cfg_q.valid && !cfg_q.bus_mode |=> sig_bidir_oe_o == $past(sb_dir))
    else $error("signaling pin direction not as programmed");
  a_ci_dir: assert property (cfg_q.valid && cfg_q.bus_mode |=> cmd_ind_bidir_oe_o == $past(ci_dir))
    else $error("command pin direction not as programmed");
  a_reset_pd: assert property (disable iff (1'b0) srst_i |=> power_down_o && ctrl_q == CTRL_RESET)
    else $error("reset did not force power-down");
  a_pd_idle: assert property (cfg_q.bus_mode && pwrdn |=> upstream_data_out_o && !sdat_oe_q)
    else $error("upstream active in power-down");

endmodule : pcmpm_top

`default_nettype wire

/* File: dv/pcmpm_ctrl_model.sv */
`default_nettype none

module pcmpm_ctrl_model (
  // Bench control
  input wire logic run_i,
  input wire logic bus_i,
  input wire logic [7:0] win_i,
  input wire logic [15:0] tx_i,
  output logic done_o,
  output logic [15:0] rx_o,
  // Link pins
  output logic lclk_o,
  output logic strobe_o,
  output logic dd_o,
  input wire logic up_i,
  input wire logic pin_dev_i,
  input wire logic pin_oe_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv;
  logic bit_v;
  logic idle_v;
  // Released pin toggles so a stale value can never pass for data
  assign pin_o = pin_oe_i ? pin_dev_i : (drv ? bit_v : idle_v);
  assign dd_o = bit_v;

  // ----------------------------------------
  // One strobe phase, clock runs only here
  // ----------------------------------------
  task automatic phase(input logic dirv, input int w, input logic send);
    for (int n = 0; n <= w + 16; n++) begin
      lclk_o = 1'b1;
      strobe_o = bus_i ? (n == 0) : dirv;
      drv = send && n >= w && n < w + 16;
      bit_v = drv ? tx_i[15 - (n - w)] : ~bit_v;
      idle_v = ~idle_v;
      #32 lclk_o = 1'b0;
      #28 if ((bus_i || !send) && n >= w && n < w + 16) rx_o[15 - (n - w)] = bus_i ? up_i : pin_o;
      #4;
    end
  endtask

  initial begin
    {lclk_o, strobe_o, drv, bit_v, idle_v, done_o, rx_o} = '0;
    forever begin
      wait (run_i);
      #1.7;
      if (bus_i) begin
        phase(1'b0, int'(win_i), 1'b1);
      end else begin
        phase(1'b1, 0, 1'b1);
        phase(1'b0, 0, 1'b0);
      end
      drv = 1'b0;
      done_o = 1'b1;
      wait (!run_i);
      done_o = 1'b0;
    end
  end
endmodule // pcmpm_ctrl_model

`default_nettype wire

/* File: dv/test_pcmpm_top.sv */
`default_nettype none

module test_pcmpm_top import pcmpm_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;
  // Index is first strap times three plus second, value {fast, slot}
  localparam logic [3:0] CFG_TAB [9] = '{4'h0, 4'hD, 4'hF, 4'h9, 4'h8, 4'hC, 4'hB, 4'hA, 4'hE};
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic mode, lclk, strb, dd, up, pin_d, pin_oe, pin_w, pdn, run, bus, done;
  logic [1:0] ts1, ts2, sb_q, sb_o, sb_oe, sb_w, ind;
  logic [5:0] sig_in, sig_out;
  logic [3:0] ci_q, ci_o, ci_oe, ci_w;
  logic [4:0] cmd;
  logic [7:0] win;
  logic [15:0] tx, rx;
  int fails = 0;
  int n_checks = 0;

  always #2.5 clk_i = ~clk_i;
  assign sb_w = (sb_oe & sb_o) | (~sb_oe & sb_q);
  assign ci_w = (ci_oe & ci_o) | (~ci_oe & ci_q);

  pcmpm_top dut (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .mode_select_i(mode), .slot_strap_first_i(ts1),
    .slot_strap_second_i(ts2), .slave_clock_i(lclk), .dir_strobe_i(strb), .shared_serial_data_pin_i(pin_w),
    .shared_serial_data_pin_o(pin_d), .shared_serial_data_pin_oe_o(pin_oe), .sig_in_i(sig_in),
    .sig_out_o(sig_out), .sig_bidir_i(sb_w), .sig_bidir_o(sb_o), .sig_bidir_oe_o(sb_oe),
    .bus_data_clock_i(lclk), .bus_frame_strobe_i(strb), .downstream_data_in_i(dd), .upstream_data_out_o(up),
    .indication_in_i(ind), .command_out_o(cmd), .cmd_ind_bidir_i(ci_w), .cmd_ind_bidir_o(ci_o),
    .cmd_ind_bidir_oe_o(ci_oe), .power_down_o(pdn));

  pcmpm_ctrl_model partner (.run_i(run), .bus_i(bus), .win_i(win), .tx_i(tx), .done_o(done), .rx_o(rx),
    .lclk_o(lclk), .strobe_o(strb), .dd_o(dd), .up_i(up), .pin_dev_i(pin_d), .pin_oe_i(pin_oe), .pin_o(pin_w));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [3:0] exp_cfg(input int a, input int b);
    return CFG_TAB[a * 3 + b];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_i);
    {hsel, haddr, hwrite, htrans} <= {1'b1, a, wr, HTRANS_NONSEQ};
    do @(posedge clk_i); while (hreadyout !== 1'b1 && ++k < 50);
    {htrans, hwdata} <= {2'h0, wd};
    do @(posedge clk_i); while (hreadyout !== 1'b1 && ++k < 100);
    rd = hrdata;
    hsel <= 1'b0;
    if (k >= 100) fails++;
  endtask

  task automatic do_reset(input logic m, input int a, input int b);
    @(posedge clk_i);
    {srst_i, mode, ts1, ts2} <= {1'b1, m, 2'(a), 2'(b)};
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // Slow-mode frames need no slot offset, so the window starts at zero
  task automatic frame(input logic b, input logic [7:0] w);
    int k;
    k = 0;
    @(posedge clk_i);
    {bus, win, tx, run} <= {b, w, 16'($urandom), 1'b1};
    do @(posedge clk_i); while (done !== 1'b1 && ++k < 20000);
    run <= 1'b0;
    repeat (10) @(posedge clk_i);
    if (k >= 20000) fails++;
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] r;
    logic [3:0] c;
    logic [6:0] c7;
    int j;
    {hsel, hwrite, htrans, haddr, hwdata, mode, ts1, ts2, run, bus, win, tx} = '0;
    {sig_in, sb_q, ind, ci_q} = '0;
    void'($urandom(801));
    do_reset(1'b1, 0, 0);
    ahb(1'b0, REG_CTRL, 32'h0, r);
    chk(r, CTRL_RESET);
    chk(pdn, 1'b1);
    ahb(1'b0, 32'h0000000C, 32'h0, r);
    chk(r, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      c = exp_cfg(i / 3, i % 3);
      do_reset(1'($urandom), i / 3, i % 3);
      {ts1, ts2} <= {2'($urandom % 3), 2'($urandom % 3)};
      repeat (4) @(posedge clk_i);
      ahb(1'b0, REG_STATUS, 32'h0, r);
      chk({r[5:3] & {3{c[3]}}, r[2:0]}, {c[2:0], c[3], mode, 1'b1});
    end
    $display("test straps done");
    // Pin directions only follow CTRL in the matching link mode, so both modes take turns
    for (int i = 0; i < 4; i++) begin
      c7 = 7'($urandom);
      do_reset(1'(i), 1, 1);
      ahb(1'b1, REG_CTRL, 32'(c7), r);
      ahb(1'b0, REG_CTRL, 32'h0, r);
      chk(r, c7);
      chk({ci_oe, sb_oe}, {mode ? c7[6:3] : 4'h0, mode ? 2'h0 : c7[2:1]});
    end
    $display("test directions done");
    for (int i = 0; i < 4; i++) begin
      j = (i == 0) ? 0 : (i == 1) ? 2 : int'($urandom % 9);
      c = exp_cfg(j / 3, j % 3);
      do_reset(1'b1, j / 3, j % 3);
      ahb(1'b1, REG_CTRL, (i == 3) ? 32'h1 : 32'h0, r);
      {ind, ci_q} <= 6'($urandom);
      frame(1'b1, c[3] ? {c[2:0], 5'h0} : 8'h0);
      if (i == 3) begin
        chk(rx, 16'hFFFF);
        chk(cmd, 5'h0);
      end else begin
        chk(rx, {ind, ci_q, 10'h0});
        chk({cmd, ci_o}, tx[15:7]);
      end
      ahb(1'b0, REG_LATCH, 32'h0, r);
      chk(r[16:8], (i == 3) ? 9'h000 : {tx[10:7], tx[15:11]});
    end
    $display("test bus frames done");
    do_reset(1'b0, 1, 1);
    for (int i = 0; i < 2; i++) begin
      {sig_in, sb_q} <= 8'($urandom);
      frame(1'b0, 8'h0);
      chk(rx, {sig_in, sb_q, 8'h0});
      chk({sig_out, sb_o}, tx[15:8]);
      ahb(1'b0, REG_LATCH, 32'h0, r);
      chk(r[7:0], {tx[9:8], tx[15:10]});
    end
    do_reset(1'b0, 1, 1);
    chk({sig_out, sb_o}, 8'h0);
    $display("test slot-link done");
    tally_and_finish();
  end
endmodule // test_pcmpm_top

`default_nettype wire
